//--- verilog/boot_cmd_params.svh
`ifndef BOOT_CMD_PARAMS_SVH
`define BOOT_CMD_PARAMS_SVH
`define OP_ID_CHECK 8'hF5
`define OP_READ_CHECK 8'hFD
`define OP_PAGE_PROG 8'h41
`define OP_BAUD_9600 8'hB0
`define OP_BAUD_19200 8'hB1
`define OP_BAUD_38400 8'hB2
`define OP_BAUD_57600 8'hB3
`define OP_BAUD_115200 8'hB4
`define ID_ADDR_LAST 24'hFFFFFB
`define ID_ADDR_SECOND_LAST 24'hFFFFF7
`define ID_LEN 7
`define PAGE_BYTES 256
`define CLK_HZ 10000000
`define RATE_DEFAULT 9600
`define CRC_POLY 16'h1021
`define CRC_SEED 16'h0000
`endif

//--- verilog/boot_cmd_pkg.sv
package boot_cmd_pkg;
  typedef enum logic [9:0] {
    ST_OP = 10'h001,
    ST_ADDR = 10'h002,
    ST_COUNT = 10'h004,
    ST_ID = 10'h008,
    ST_PAGE_ADDR = 10'h010,
    ST_PAGE_DATA = 10'h020,
    ST_TX_LO = 10'h040,
    ST_TX_HI = 10'h080,
    ST_ECHO = 10'h100,
    ST_SWITCH = 10'h200
  } cmd_state_e;
  typedef logic [15:0] divisor_t;
endpackage

//--- verilog/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

//--- verilog/boot_cmd_engine.sv
// Functional notes
// RULE1: when flash is not blank the received id code is compared with the stored one first.
// RULE2: after an id mismatch every following command other than F5 is ignored.
// RULE3: each stored id element is one 8-bit byte at its own flash location.
// RULE4: id bytes are read from fixed top addresses, the last two ending F7 and FB.
// RULE5: the programmer sends F5, a three-byte first address, a count, then the code bytes.
// RULE6: after opcode FD the check value is sent low byte first, then high byte.
// RULE7: reading the check value restarts accumulation over later page program data.
// RULE8: the check value is a CRC over every page program write data byte; the crc skips any byte that a full fifo drops.
// RULE9: the CRC is 16 bits with parameterised polynomial and seed, one byte per step.
// RULE10: page program carries 41, page address middle and high, then 256 data bytes.
// RULE11: opcode B0 is echoed and the rate then becomes 9600 bit/s.
// RULE12: opcode B1 is echoed and the rate then becomes 19200 bit/s.
// RULE13: opcode B2 is echoed and the rate then becomes 38400 bit/s.
// RULE14: opcode B3 is echoed and the rate then becomes 57600 bit/s.
// RULE15: opcode B4 is echoed and the rate then becomes 115200 bit/s.
// RULE16: the new rate takes effect only after the echo has been fully sent at the old rate.
// RULE17: the divisor is reloaded in one step at the end of the echo stop bit.
`include "boot_cmd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_engine
  import boot_cmd_pkg::*;
#(
  parameter int CLK_HZ = `CLK_HZ,
  parameter logic [15:0] CRC_POLY = `CRC_POLY,
  parameter logic [15:0] CRC_SEED = `CRC_SEED,
  parameter int ID_LEN = `ID_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_receive_line,
  output logic serial_transmit_line,
  input wire logic flash_blank,
  output logic [23:0] id_fetch_addr,
  input wire logic [7:0] id_fetch_data,
  output logic id_ok,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_data,
  output logic [23:0] wr_page_addr,
  output logic [2:0] rate_sel
);
  function automatic divisor_t rate_div(input logic [2:0] sel);
    int unsigned bps;
    bps = `RATE_DEFAULT;
    case (sel)
      3'h1: bps = 19200;
      3'h2: bps = 38400;
      3'h3: bps = 57600;
      3'h4: bps = 115200;
      default: bps = `RATE_DEFAULT;
    endcase
    return divisor_t'(CLK_HZ / bps);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // id code addresses, last two are the fixed top ones
  function automatic logic [23:0] id_addr(input logic [2:0] k);
    logic [23:0] a;
    a = `ID_ADDR_LAST - 24'(4 * (ID_LEN - 1 - int'(k)));
    return a;
  endfunction // RULE4

  // pin synchroniser
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_receive_line;
      rx_sync <= rx_meta;
    end
  end

  divisor_t divisor;
  // receiver: sample each bit at mid point
  logic rx_busy;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_strobe;
  logic [7:0] rx_byte;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_strobe <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_strobe <= 1'b0;
      if (!rx_busy) begin
        if (!rx_sync) begin
          rx_busy <= 1'b1;
          rx_cnt <= divisor >> 1;
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= divisor - 1'b1;
        rx_bit <= rx_bit + 1'b1;
        if (rx_bit == 4'h0 && rx_sync) begin
          rx_busy <= 1'b0;
        end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
          rx_sh <= {rx_sync, rx_sh[7:1]};
        end else if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          rx_strobe <= rx_sync;
          rx_byte <= rx_sh;
        end
      end
    end
  end

  // transmitter
  logic tx_start;
  logic [7:0] tx_byte;
  logic tx_busy;
  logic tx_done;
  logic [15:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_sh;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
      serial_transmit_line <= 1'b1;
    end else begin
      tx_done <= 1'b0;
      if (!tx_busy) begin
        serial_transmit_line <= 1'b1;
        if (tx_start) begin
          tx_busy <= 1'b1;
          tx_sh <= {1'b1, tx_byte, 1'b0};
          tx_bit <= 4'h0;
          tx_cnt <= divisor - 1'b1;
          serial_transmit_line <= 1'b0;
        end
      end else if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_bit == 4'h9) begin
        // stop bit complete
        tx_busy <= 1'b0;
        tx_done <= 1'b1;
      end else begin
        tx_cnt <= divisor - 1'b1;
        tx_bit <= tx_bit + 1'b1;
        serial_transmit_line <= tx_sh[tx_bit+1];
      end
    end
  end

  // command sequencer
  cmd_state_e state;
  logic locked;
  logic [1:0] byte_idx;
  logic [2:0] id_idx;
  logic [7:0] id_count;
  logic id_match;
  logic [15:0] crc;
  logic [8:0] data_left;
  logic [2:0] pending_rate;
  logic fifo_in_valid;
  logic fifo_in_ready;
  assign fifo_in_valid = (state == ST_PAGE_DATA) && rx_strobe;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_OP;
      byte_idx <= 2'd0;
      id_idx <= 3'd0;
      id_count <= 8'h00;
      id_match <= 1'b1;
      locked <= 1'b1;
      data_left <= 9'd0;
      wr_page_addr <= 24'h000000;
      pending_rate <= 3'd0;
      tx_start <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_start <= 1'b0;
      case (state)
        ST_OP: if (rx_strobe) begin
          byte_idx <= 2'd0;
          if (rx_byte == `OP_ID_CHECK) begin
            state <= ST_ADDR; // RULE5
          end else if (!id_ok) begin
            state <= ST_OP; // RULE2
          end else if (rx_byte == `OP_READ_CHECK) begin
            tx_byte <= crc[7:0]; // RULE6
            tx_start <= 1'b1;
            state <= ST_TX_LO;
          end else if (rx_byte == `OP_PAGE_PROG) begin
            state <= ST_PAGE_ADDR; // RULE10
          end else if (rx_byte >= `OP_BAUD_9600 && rx_byte <= `OP_BAUD_115200) begin
            pending_rate <= rx_byte[2:0]; // RULE11 RULE12 RULE13 RULE14 RULE15
            tx_byte <= rx_byte;
            tx_start <= 1'b1;
            state <= ST_ECHO;
          end
        end
        ST_ADDR: if (rx_strobe) begin
          byte_idx <= byte_idx + 1'b1;
          if (byte_idx == 2'd2) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: if (rx_strobe) begin
          id_count <= rx_byte;
          id_idx <= 3'd0;
          id_match <= 1'b1;
          state <= (rx_byte == 8'h00) ? ST_OP : ST_ID;
        end
        ST_ID: if (rx_strobe) begin
          // each code byte meets its own stored byte
          if (rx_byte != id_fetch_data || int'(id_idx) >= ID_LEN) begin
            id_match <= 1'b0; // RULE1 RULE3
          end
          id_idx <= id_idx + 1'b1;
          id_count <= id_count - 1'b1;
          if (id_count == 8'h01) begin
            locked <= !(id_match && rx_byte == id_fetch_data
                        && int'(id_idx) == ID_LEN - 1); // RULE2
            state <= ST_OP;
          end
        end
        ST_PAGE_ADDR: if (rx_strobe) begin
          byte_idx <= byte_idx + 1'b1;
          if (byte_idx == 2'd0) begin
            wr_page_addr[15:8] <= rx_byte;
          end else begin
            wr_page_addr[23:16] <= rx_byte;
            wr_page_addr[7:0] <= 8'h00;
            data_left <= 9'(`PAGE_BYTES);
            state <= ST_PAGE_DATA;
          end
        end
        ST_PAGE_DATA: if (rx_strobe) begin
          // a full fifo drops the byte; the crc then flags the loss
          data_left <= data_left - 1'b1;
          if (data_left == 9'd1) begin
            state <= ST_OP;
          end
        end
        ST_TX_LO: if (tx_done) begin
          tx_byte <= crc[15:8];
          tx_start <= 1'b1;
          state <= ST_TX_HI;
        end
        ST_TX_HI: if (tx_done) begin
          state <= ST_OP;
        end
        ST_ECHO: if (tx_done) begin
          state <= ST_SWITCH; // RULE16
        end
        ST_SWITCH: state <= ST_OP;
        default: state <= ST_OP;
      endcase
    end
  end

  // blank flash needs no id; registered, the one cycle of lag is far inside a byte time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      id_ok <= 1'b0;
    end else begin
      id_ok <= flash_blank || !locked; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      id_fetch_addr <= `ID_ADDR_LAST;
    end else begin
      id_fetch_addr <= id_addr(id_idx); // RULE4
    end
  end

  // divisor swaps only once the echo stop bit has finished
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_sel <= 3'd0;
      divisor <= rate_div(3'd0);
    end else if (state == ST_ECHO && tx_done) begin
      rate_sel <= pending_rate; // RULE17
      divisor <= rate_div(pending_rate); // RULE16
    end
  end

  // crc restarts after the high byte of a read has been sent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc <= CRC_SEED;
    end else if (state == ST_TX_HI && tx_done) begin
      crc <= CRC_SEED; // RULE7
    end else if (fifo_in_valid && fifo_in_ready) begin
      crc <= crc_byte(crc, rx_byte); // RULE8 RULE9
    end
  end

  // output stage so the write stream leaves from flops; costs one cycle of latency
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  assign fifo_out_ready = !wr_valid || wr_ready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
    end else if (fifo_out_ready) begin
      wr_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        wr_data <= fifo_out_data;
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_byte),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
endmodule // boot_cmd_engine
`default_nettype wire

//--- test/boot_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none
module boot_cmd_sva #(parameter int CLK_HZ = 10000000) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_receive_line,
  input wire logic serial_transmit_line,
  input wire logic flash_blank,
  input wire logic [23:0] id_fetch_addr,
  input wire logic id_ok,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rate_sel
);
  localparam int MIN_STOP = CLK_HZ / 115200 - 1;
  int unsigned tx_high;
  // a switch inside a character would garble it, so the line must have idled one 115200 bit time less one cycle
  always_ff @(posedge clk) begin
    if (!rst_n || !serial_transmit_line) begin
      tx_high <= 0;
    end else begin
      tx_high <= tx_high + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rate_move;
    $changed(rate_sel);
  endsequence
  sequence s_stall;
    wr_valid && !wr_ready;
  endsequence
  chk_rate_after_stop: assert property (s_rate_move |-> tx_high >= MIN_STOP)
    else $error("rate moved inside a character");
  chk_rate_legal: assert property (rate_sel <= 3'h4)
    else $error("rate code out of range");
  chk_blank_open: assert property (flash_blank |=> id_ok)
    else $error("blank flash still locked");
  chk_locked_quiet: assert property (!id_ok |-> serial_transmit_line)
    else $error("answer sent while locked");
  chk_unlock_at_stop: assert property ($rose(id_ok) && !flash_blank
    |-> $past(serial_receive_line, 3)) else $error("unlock away from a stop bit");
  chk_write_gated: assert property (wr_valid |-> id_ok)
    else $error("write data while locked");
  chk_wr_hold: assert property (s_stall |=> wr_valid && $stable(wr_data))
    else $error("write data dropped while stalled");
  chk_id_window: assert property ($changed(id_fetch_addr) |-> id_fetch_addr[23:8] == 16'hFFFF)
    else $error("id fetch outside top area");
endmodule // boot_cmd_sva
bind boot_cmd_engine boot_cmd_sva #(.CLK_HZ(CLK_HZ)) sva_u (.clk, .rst_n, .serial_receive_line,
  .serial_transmit_line, .flash_blank, .id_fetch_addr, .id_ok, .wr_valid, .wr_ready, .wr_data,
  .rate_sel);
`default_nettype wire

//--- test/prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_model #(parameter int CLK_HZ = 10000000) (
  input wire logic clk,
  output logic serial_receive_line,
  input wire logic serial_transmit_line,
  input wire logic [23:0] id_fetch_addr,
  output logic [7:0] id_fetch_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data
);
  int bit_cyc = CLK_HZ / 9600;
  int cyc = 0;
  logic [7:0] got[$];
  initial serial_receive_line = 1'b1;
  // stored id byte derived from its own address
  assign id_fetch_data = id_fetch_addr[7:0] ^ 8'h5A;
  // sink stalls most cycles so the fifo really holds data; valid and data stand until
  // the next rising edge, so a transfer is booked here instead of racing that edge
  always @(negedge clk) begin
    cyc = cyc + 1;
    wr_ready = cyc[4:0] > 5'h1B;
    if (wr_valid && wr_ready) got.push_back(wr_data);
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    repeat (bit_cyc) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      serial_receive_line = f[i];
      repeat (bit_cyc) @(negedge clk);
    end
    serial_receive_line = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic recv(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (serial_transmit_line !== 1'b0 && n < 30 * bit_cyc) begin
      @(negedge clk);
      n++;
    end
    ok = n < 30 * bit_cyc;
    if (ok) begin
      repeat (bit_cyc / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(negedge clk);
        d[i] = serial_transmit_line;
      end
      repeat (bit_cyc) @(negedge clk);
      ok = serial_transmit_line === 1'b1;
    end
  endtask
endmodule // prog_model
`default_nettype wire

//--- test/boot_cmd_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "boot_cmd_params.svh"
`define CHECK(g, e, m) tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t %s", $time, m); end
module boot_cmd_engine_tb_top;
  localparam int HZ = 1152000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic flash_blank = 1'b1;
  logic rx, tx, id_ok, wr_valid, wr_ready, ok;
  logic [23:0] id_fetch_addr, wr_page_addr;
  logic [7:0] id_fetch_data, wr_data, b;
  logic [2:0] rate_sel;
  int fails = 0;
  int tests_run = 0;
  int rates[5] = '{9600, 19200, 38400, 57600, 115200};
  always #50 clk = ~clk;
  boot_cmd_engine #(.CLK_HZ(HZ)) dut_u (.clk, .rst_n, .serial_receive_line(rx),
    .serial_transmit_line(tx), .flash_blank, .id_fetch_addr, .id_fetch_data, .id_ok,
    .wr_valid, .wr_ready, .wr_data, .wr_page_addr, .rate_sel);
  prog_model #(.CLK_HZ(HZ)) prog_u (.clk, .serial_receive_line(rx), .serial_transmit_line(tx),
    .id_fetch_addr, .id_fetch_data, .wr_valid, .wr_ready, .wr_data);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++)
      c = c[15] ? (c << 1) ^ `CRC_POLY : c << 1;
    return c;
  endfunction
  task automatic t_baud();
    for (int i = 0; i < 5; i++) begin
      prog_u.send(8'hB0 + 8'(i));
      prog_u.recv(b, ok);
      `CHECK(b, 8'hB0 + 8'(i), "echo")
      `CHECK(rate_sel, 3'(i == 0 ? 0 : i - 1), "early switch")
      repeat (prog_u.bit_cyc) @(negedge clk);
      `CHECK(rate_sel, 3'(i), "rate code")
      prog_u.bit_cyc = HZ / rates[i];
    end
  endtask
  task automatic send_id(input logic [7:0] flip);
    prog_u.send(`OP_ID_CHECK);
    prog_u.send(8'hE3);
    prog_u.send(8'hFF);
    prog_u.send(8'hFF);
    prog_u.send(8'(`ID_LEN));
    for (int k = 0; k < `ID_LEN; k++)
      prog_u.send((8'hE3 + 8'(4 * k)) ^ 8'h5A ^ flip);
    repeat (prog_u.bit_cyc) @(negedge clk);
  endtask
  task automatic t_lock();
    flash_blank = 1'b0;
    @(negedge clk);
    `CHECK(id_ok, 1'b0, "not locked")
    send_id(8'h01);
    `CHECK(id_ok, 1'b0, "bad id accepted")
    prog_u.send(`OP_READ_CHECK);
    prog_u.recv(b, ok);
    `CHECK(ok, 1'b0, "answer while locked")
    send_id(8'h00);
    `CHECK(id_ok, 1'b1, "good id refused")
  endtask
  task automatic read_check(input logic [15:0] e);
    logic [7:0] lo;
    prog_u.send(`OP_READ_CHECK);
    prog_u.recv(lo, ok);
    prog_u.recv(b, ok);
    `CHECK({b, lo}, e, "check value")
  endtask
  task automatic t_crc();
    logic [15:0] crc;
    crc = `CRC_SEED;
    read_check(`CRC_SEED);
    prog_u.send(`OP_PAGE_PROG);
    prog_u.send(8'h34);
    prog_u.send(8'h12);
    for (int i = 0; i < `PAGE_BYTES; i++) begin
      prog_u.send(8'(i) ^ 8'hC3);
      crc = crc_step(crc, 8'(i) ^ 8'hC3);
    end
    read_check(crc);
    `CHECK(prog_u.got.size(), `PAGE_BYTES, "data count")
    for (int i = 0; i < prog_u.got.size(); i++) begin
      `CHECK(prog_u.got[i], 8'(i) ^ 8'hC3, "page data")
    end
    `CHECK(wr_page_addr, 24'h123400, "page address")
    read_check(`CRC_SEED);
  endtask
  task automatic end_of_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_baud();
    t_lock();
    t_crc();
    end_of_test();
  end
  initial begin
    repeat (60000) @(negedge clk);
    fails++;
    end_of_test();
  end
endmodule // boot_cmd_engine_tb_top
`default_nettype wire
